// file: rtl/pph_regs.svh
// Register map, field positions and fixed values of the path point handshake block.
// Assumes a 32-bit APB bus with byte addresses; included by the ramp checker, the sequencer and the bench.
// Operation
// - Helical points regulate speed along the circumference.
// - Linear and circular points regulate combined speed of all axes.
// - Asserted skip input abandons the current point and starts the next.
// - Skip on the final point decelerates to a stop and ends the path.
// - Negative speed change on a helical point may step back one point.
// - Speed-switching flag works on helical points as on others.
// - Finish-wait mode always uses the fixed ramp time.
// - Ramp time is given directly or read from one data word.
// - Out-of-range ramp at start reports error 13 and uses 1000 ms.
// - Tag strobe goes to every interpolating axis; acknowledge comes on one.
// - Helical points strobe all axes and accept acknowledge on any.
// - Starting a tagged point presents its tag and raises the strobe.
// - Finish-wait mode holds the next point until acknowledge arrives.
// - Strobe drops as soon as acknowledge is seen high.
// - Next positioning waits for acknowledge to return low.
// - Tagged final point completes after acknowledge low, high, low.
`ifndef PPH_REGS_SVH
`define PPH_REGS_SVH
`define PPH_A_CTRL      12'h000
`define PPH_A_RAMP      12'h004
`define PPH_A_DWORD     12'h008
`define PPH_A_STATUS    12'h00c
`define PPH_A_ERR       12'h010
`define PPH_A_PT_BASE   12'h040
`define PPH_CTRL_START  0
`define PPH_CTRL_FIN    1
`define PPH_CTRL_LAST   4
`define PPH_CTRL_AXES   8
`define PPH_RAMP_IND    16
`define PPH_PT_TAG      0
`define PPH_PT_KIND     8
`define PPH_PT_HASTAG   10
`define PPH_PT_SPSW     11
`define PPH_PT_SKEN     12
`define PPH_PT_SKSEL    13
`define PPH_ST_IDX      4
`define PPH_ST_BUSY     8
`define PPH_ST_STROBE   9
`define PPH_ST_ACK      10
`define PPH_ERR_RAMP    8'h0d
`define PPH_RAMP_MIN    16'h0001
`define PPH_RAMP_MAX    16'h1388
`define PPH_RAMP_DEF    16'h03e8
`define PPH_AXES_RST    4'h3
`endif

// file: rtl/pph_pkg.sv
// Shared types of the path point handshake block.
// Assumes nothing of its surroundings.
package pph_pkg;
  // Sequencer states, Gray coded along idle, run, hold, release.
  typedef enum logic [2:0] {
    PPH_IDLE = 3'h0,
    PPH_RUN  = 3'h1,
    PPH_HOLD = 3'h3,
    PPH_REL  = 3'h2,
    PPH_STOP = 3'h6
  } pph_state_e;
  // Interpolation kind of a pass point.
  typedef enum logic [1:0] {
    PPH_LIN  = 2'h0,
    PPH_CIRC = 2'h1,
    PPH_HELI = 2'h2
  } pph_kind_e;
endpackage : pph_pkg

// file: rtl/pph_ramp_if.sv
// Carrier between the sequencer and the ramp time checker.
// Assumes both ends run on the same clock.
interface pph_ramp_if;
  logic [15:0] direct;
  logic        indirect;
  logic [15:0] word;
  logic [15:0] ms;
  logic        bad;
  modport cfg (output direct, output indirect, output word, input ms, input bad);
  modport chk (input direct, input indirect, input word, output ms, output bad);
endinterface : pph_ramp_if

// file: rtl/pph_sync.sv
// Two-stage synchroniser for a vector of pin inputs.
// Assumes each bit is an independent level from outside the pclk domain.
module pph_sync #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } pph_sync_s;
  pph_sync_s s_q, s_d;

  // The first stage feeds only the second stage.
  always_comb begin
    s_d      = s_q;
    s_d.meta = din;
    s_d.stab = s_q.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.stab;
endmodule : pph_sync

// file: rtl/pph_ramp.sv
// Fixed ramp time selection and range check for finish-wait mode.
// Assumes the interface inputs come from registers on pclk.
`include "pph_regs.svh"
module pph_ramp (
  input  wire logic pclk,
  input  wire logic presetn,
  pph_ramp_if.chk   rif
);
  typedef struct packed {
    logic [15:0] ms;
    logic        bad;
  } pph_ramp_s;
  pph_ramp_s s_q, s_d;
  logic [15:0] val;

  // An indirect setting reads the single data word.
  always_comb begin
    val     = rif.indirect ? rif.word : rif.direct;
    s_d.bad = (val < `PPH_RAMP_MIN) || (val > `PPH_RAMP_MAX);
    s_d.ms  = s_d.bad ? `PPH_RAMP_DEF : val;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{ms: `PPH_RAMP_DEF, bad: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rif.ms  = s_q.ms;
  assign rif.bad = s_q.bad;

  AST_RAMP_DEF: assert property (@(posedge pclk) disable iff (!presetn)
    rif.bad |-> rif.ms == `PPH_RAMP_DEF) else $error("Bad ramp not replaced by default.");
endmodule : pph_ramp

// file: rtl/pph_path_seq.sv
// Pass point sequencer with skip, step back and tag/finish handshake.
// Assumes an APB master on pclk, an interpolator on pclk giving seg_done and
// speed_neg, and skip and acknowledge pins from outside the clock domain.
`include "pph_regs.svh"
module pph_path_seq #(
  parameter int NPTS  = 8,
  parameter int NAXES = 4,
  parameter int NSKIP = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [11:0]      paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [NSKIP-1:0] skip_in,
  input  wire logic [NAXES-1:0] fin_ack_in,
  input  wire logic             seg_done,
  input  wire logic             speed_neg,
  output logic                  seg_start,
  output logic [$clog2(NPTS)-1:0] point_idx,
  output logic                  speed_circ,
  output logic                  speed_switch,
  output logic                  fixed_ramp,
  output logic [15:0]           ramp_ms,
  output logic                  decel_stop,
  output logic                  path_done,
  output logic [7:0]            tag_code,
  output logic [NAXES-1:0]      tag_valid
);
  localparam int IW = $clog2(NPTS);
  localparam int SW = $clog2(NSKIP);

  typedef struct packed {
    logic [NPTS-1:0][15:0] pt;
    logic                  fin_mode;
    logic [NAXES-1:0]      axes;
    logic [IW-1:0]         last;
    logic [16:0]           ramp;
    logic [15:0]           dword;
    logic [7:0]            err;
    logic [31:0]           rdata;
    pph_pkg::pph_state_e   st;
    logic [IW-1:0]         idx;
    logic [7:0]            tag;
    logic                  strobe;
    logic                  ack_seen;
    logic [NSKIP-1:0]      skip_prev;
    logic                  seg_start;
    logic                  decel_stop;
    logic                  path_done;
  } pph_main_s;
  pph_main_s s_q, s_d;

  logic [NSKIP-1:0] skip_s;
  logic [NAXES-1:0] ack_s;
  logic             fin_any;
  logic             skip_rise;
  logic             is_last;
  logic             wr;
  logic             hit;
  logic [15:0]      cur;
  pph_ramp_if       rif ();

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Interpolation kind of a point word.
  function automatic pph_pkg::pph_kind_e fn_kind(input logic [15:0] p);
    fn_kind = pph_pkg::pph_kind_e'(p[`PPH_PT_KIND +: 2]);
  endfunction : fn_kind

  // Byte address of a point word; index widths stay inside the 12-bit bus.
  function automatic logic [11:0] fn_pt_addr(input int i);
    fn_pt_addr = `PPH_A_PT_BASE + 12'(i * 4);
  endfunction : fn_pt_addr

  // Begin positioning toward point i with its tag presented.
  function automatic pph_main_s fn_go(input pph_main_s s, input logic [IW-1:0] i);
    pph_main_s r;
    r           = s;
    r.st        = pph_pkg::PPH_RUN;
    r.idx       = i;
    r.tag       = s.pt[i][`PPH_PT_TAG +: 8];
    r.strobe    = s.pt[i][`PPH_PT_HASTAG];
    r.ack_seen  = 1'b0;
    r.seg_start = 1'b1;
    return r;
  endfunction : fn_go

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and ramp checker.

  pph_sync #(.W(NSKIP)) u_skip_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (skip_in),
    .dout    (skip_s)
  );

  pph_sync #(.W(NAXES)) u_ack_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (fin_ack_in),
    .dout    (ack_s)
  );

  assign rif.direct   = s_q.ramp[15:0];
  assign rif.indirect = s_q.ramp[`PPH_RAMP_IND];
  assign rif.word     = s_q.dword;

  pph_ramp u_ramp (
    .pclk    (pclk),
    .presetn (presetn),
    .rif     (rif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decoded conditions.

  // An acknowledge on any enabled axis counts, so a helical point answers on either kind.
  assign fin_any   = |(ack_s & s_q.axes);
  assign cur       = s_q.pt[s_q.idx];
  assign is_last   = (s_q.idx == s_q.last);
  // Edge, not level, so a held skip does not also skip the following point.
  assign skip_rise = cur[`PPH_PT_SKEN] && skip_s[cur[`PPH_PT_SKSEL +: SW]] && !s_q.skip_prev[cur[`PPH_PT_SKSEL +: SW]];
  assign wr        = psel && penable && pwrite;

  // Address decode; anything else answers with an error.
  always_comb begin
    hit = (paddr == `PPH_A_CTRL) || (paddr == `PPH_A_RAMP) || (paddr == `PPH_A_DWORD) ||
          (paddr == `PPH_A_STATUS) || (paddr == `PPH_A_ERR);
    for (int i = 0; i < NPTS; i++) begin
      if (paddr == fn_pt_addr(i)) begin
        hit = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: bus access, then sequencing.

  always_comb begin
    s_d            = s_q;
    s_d.seg_start  = 1'b0;
    s_d.decel_stop = 1'b0;
    s_d.path_done  = 1'b0;
    s_d.skip_prev  = skip_s;

    // Read data is captured in the setup cycle so the access cycle needs no wait.
    if (psel && !penable && !pwrite) begin
      s_d.rdata = '0;
      case (paddr)
        `PPH_A_CTRL: begin
          s_d.rdata[`PPH_CTRL_FIN]            = s_q.fin_mode;
          s_d.rdata[`PPH_CTRL_LAST +: IW]     = s_q.last;
          s_d.rdata[`PPH_CTRL_AXES +: NAXES]  = s_q.axes;
        end
        `PPH_A_RAMP:  s_d.rdata[16:0] = s_q.ramp;
        `PPH_A_DWORD: s_d.rdata[15:0] = s_q.dword;
        `PPH_A_STATUS: begin
          s_d.rdata[2:0]                = s_q.st;
          s_d.rdata[`PPH_ST_IDX +: IW]  = s_q.idx;
          s_d.rdata[`PPH_ST_BUSY]       = (s_q.st != pph_pkg::PPH_IDLE);
          s_d.rdata[`PPH_ST_STROBE]     = s_q.strobe;
          s_d.rdata[`PPH_ST_ACK]        = fin_any;
        end
        `PPH_A_ERR:   s_d.rdata[7:0] = s_q.err;
        default: begin
          for (int i = 0; i < NPTS; i++) begin
            if (paddr == fn_pt_addr(i)) begin
              s_d.rdata[15:0] = s_q.pt[i];
            end
          end
        end
      endcase
    end

    // Writes take effect at the access edge.
    if (wr) begin
      case (paddr)
        `PPH_A_CTRL: begin
          s_d.fin_mode = pwdata[`PPH_CTRL_FIN];
          s_d.last     = pwdata[`PPH_CTRL_LAST +: IW];
          s_d.axes     = pwdata[`PPH_CTRL_AXES +: NAXES];
        end
        `PPH_A_RAMP:  s_d.ramp  = pwdata[16:0];
        `PPH_A_DWORD: s_d.dword = pwdata[15:0];
        `PPH_A_ERR:   s_d.err   = '0;
        default: begin
          for (int i = 0; i < NPTS; i++) begin
            if (paddr == fn_pt_addr(i)) begin
              s_d.pt[i] = pwdata[15:0];
            end
          end
        end
      endcase
    end

    // Path start; error set comes after the clear so it wins.
    if (wr && paddr == `PPH_A_CTRL && pwdata[`PPH_CTRL_START] && s_q.st == pph_pkg::PPH_IDLE) begin
      if (pwdata[`PPH_CTRL_FIN] && rif.bad) begin
        s_d.err = `PPH_ERR_RAMP;
      end
      s_d = fn_go(s_d, '0);
    end

    case (s_q.st)
      pph_pkg::PPH_IDLE: ;
      pph_pkg::PPH_RUN: begin
        if (s_q.strobe && fin_any) begin
          s_d.strobe   = 1'b0;
          s_d.ack_seen = 1'b1;
        end
        if (skip_rise) begin
          if (is_last) begin
            s_d.st         = pph_pkg::PPH_STOP;
            s_d.decel_stop = 1'b1;
            s_d.strobe     = 1'b0;
          end else begin
            s_d = fn_go(s_d, s_q.idx + 1'b1);
          end
        end else if (speed_neg && fn_kind(cur) == pph_pkg::PPH_HELI && s_q.idx != '0) begin
          s_d = fn_go(s_d, s_q.idx - 1'b1);
        end else if (seg_done) begin
          // Tagged points wait in finish-wait mode, and a tagged final point always waits.
          if (cur[`PPH_PT_HASTAG] && (s_q.fin_mode || is_last)) begin
            s_d.st = (s_q.ack_seen || fin_any) ? pph_pkg::PPH_REL : pph_pkg::PPH_HOLD;
          end else if (is_last) begin
            s_d.st        = pph_pkg::PPH_IDLE;
            s_d.strobe    = 1'b0;
            s_d.path_done = 1'b1;
          end else begin
            s_d = fn_go(s_d, s_q.idx + 1'b1);
          end
        end
      end
      pph_pkg::PPH_HOLD: begin
        if (fin_any) begin
          s_d.strobe = 1'b0;
          s_d.st     = pph_pkg::PPH_REL;
        end
      end
      pph_pkg::PPH_REL: begin
        if (!fin_any) begin
          if (is_last) begin
            s_d.st        = pph_pkg::PPH_IDLE;
            s_d.path_done = 1'b1;
          end else begin
            s_d = fn_go(s_d, s_q.idx + 1'b1);
          end
        end
      end
      pph_pkg::PPH_STOP: begin
        if (seg_done) begin
          s_d.st        = pph_pkg::PPH_IDLE;
          s_d.path_done = 1'b1;
        end
      end
      default: s_d.st = pph_pkg::PPH_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q      <= '0;
      s_q.axes <= `PPH_AXES_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign prdata       = s_q.rdata;
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !hit;
  assign seg_start    = s_q.seg_start;
  assign point_idx    = s_q.idx;
  assign speed_circ   = (fn_kind(cur) == pph_pkg::PPH_HELI);
  assign speed_switch = cur[`PPH_PT_SPSW];
  assign fixed_ramp   = s_q.fin_mode;
  assign ramp_ms      = rif.ms;
  assign decel_stop   = s_q.decel_stop;
  assign path_done    = s_q.path_done;
  assign tag_code     = s_q.tag;
  assign tag_valid    = {NAXES{s_q.strobe}} & s_q.axes;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_TAG_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.strobe && $past(s_q.strobe) |-> s_q.tag == $past(s_q.tag)) else $error("Tag changed under strobe.");
  AST_STROBE_DROP: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.strobe && fin_any && s_q.st != pph_pkg::PPH_IDLE && !s_d.seg_start |=> !s_q.strobe)
    else $error("Strobe held after acknowledge.");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == pph_pkg::PPH_HOLD && !fin_any |=> s_q.st == pph_pkg::PPH_HOLD && !s_q.seg_start)
    else $error("Advanced without acknowledge.");
  AST_REL_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == pph_pkg::PPH_REL && fin_any |=> !s_q.seg_start && !s_q.path_done)
    else $error("Advanced while acknowledge high.");
  AST_START_TAG: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.seg_start |-> s_q.strobe == cur[`PPH_PT_HASTAG] && s_q.tag == cur[`PPH_PT_TAG +: 8])
    else $error("Tag not presented at point start.");
  AST_SKIP: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == pph_pkg::PPH_RUN && skip_rise && !is_last && !(wr && paddr == `PPH_A_CTRL)
    |=> s_q.seg_start && s_q.idx == $past(s_q.idx) + 1'b1) else $error("Skip did not advance.");
  AST_SKIP_END: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == pph_pkg::PPH_RUN && skip_rise && is_last
    |=> s_q.decel_stop && s_q.st == pph_pkg::PPH_STOP) else $error("Final skip did not stop.");
  AST_BACK: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == pph_pkg::PPH_RUN && !skip_rise && speed_neg && speed_circ && s_q.idx != '0
    |=> s_q.idx == $past(s_q.idx) - 1'b1) else $error("No step back on helical point.");
  AST_ERR13: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `PPH_A_CTRL && pwdata[`PPH_CTRL_START] && pwdata[`PPH_CTRL_FIN] && rif.bad &&
    s_q.st == pph_pkg::PPH_IDLE |=> s_q.err == `PPH_ERR_RAMP) else $error("Ramp error not reported.");

  COV_SKIP: cover property (@(posedge pclk) disable iff (!presetn) s_q.st == pph_pkg::PPH_RUN && skip_rise);
  COV_DONE: cover property (@(posedge pclk) disable iff (!presetn) s_q.path_done);
  COV_HOLD: cover property (@(posedge pclk) disable iff (!presetn)
    s_q.st == pph_pkg::PPH_HOLD ##1 s_q.st == pph_pkg::PPH_REL);
endmodule : pph_path_seq

// file: tb/pph_host_model.sv
// Host sequencing model that answers the tag strobe with a finish acknowledge.
// Assumes tag_valid comes from the design on pclk and ack_sel names an axis in the mask.
module pph_host_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] tag_valid,
  input  wire logic [1:0] ack_sel,
  input  wire logic [3:0] ack_dly,
  output logic      [3:0] fin_ack_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       ack_q;
  logic [3:0] cnt_q;
  logic       act;
  ////////////////////////////////////////////////////////////////////////////////
  // Raise after ack_dly cycles of strobe, release ack_dly cycles after it drops.
  // Releasing late, never early, keeps the design from seeing a half handshake.
  assign act = ack_q ? (tag_valid == 4'h0) : tag_valid[ack_sel];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (act && cnt_q == ack_dly) begin
      ack_q <= !ack_q;
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= act ? cnt_q + 4'h1 : 4'h0;
    end
  end
  // The acknowledge is given on one axis only, whichever the bench picks.
  assign fin_ack_in = ack_q ? (4'h1 << ack_sel) : 4'h0;
endmodule : pph_host_model

// file: tb/pph_path_seq_tb_top.sv
// Self-checking bench of the pass point sequencer: APB master, pin stimulus, result queue.
// Assumes the host model answers the strobe and that everything runs on pclk.
`include "pph_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAITFOR(c) begin while (!(c)) begin @(posedge pclk); end end
module pph_path_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, rnd;
  logic        seg_done, speed_neg, seg_start, speed_circ, speed_switch, fixed_ramp, decel_stop, path_done, e;
  logic [3:0]  skip_in, fin_ack_in, tag_valid, tv_d, ack_dly, cnt;
  logic [2:0]  point_idx;
  logic [1:0]  ack_sel;
  logic [15:0] ramp_ms;
  logic [7:0]  tag_code, tag_d, t;
  logic [17:0] exp_q[$], x;
  logic        ack_seen, ack_d;
  int          n_fail, tests_run, cyc;
  pph_path_seq i_pph_path_seq (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .skip_in(skip_in),
    .fin_ack_in(fin_ack_in), .seg_done(seg_done), .speed_neg(speed_neg), .seg_start(seg_start),
    .point_idx(point_idx), .speed_circ(speed_circ), .speed_switch(speed_switch), .fixed_ramp(fixed_ramp),
    .ramp_ms(ramp_ms), .decel_stop(decel_stop), .path_done(path_done), .tag_code(tag_code), .tag_valid(tag_valid));
  pph_host_model i_pph_host_model (.pclk(pclk), .presetn(presetn), .tag_valid(tag_valid), .ack_sel(ack_sel),
    .ack_dly(ack_dly), .fin_ack_in(fin_ack_in));
  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Xorshift source; one step per call.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  // One APB transfer; entered just after a rising edge, released only after pready.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never reassigns psel in the same time step.
    @(posedge pclk);
  endtask : apb
  // Point entry: f is skip select, skip enable, speed switch and has-tag, from the top.
  task automatic pt(input int i, input logic [7:0] tg, input logic [1:0] k, input logic [4:0] f);
    apb(1'b1, `PPH_A_PT_BASE + 12'(4 * i), {17'h0, f, k, tg});
  endtask : pt
  // Start a path: fin mode, last index and axis mask.
  task automatic start(input logic fin, input logic [2:0] last, input logic [3:0] ax);
    apb(1'b1, `PPH_A_CTRL, {20'h0, ax, 1'b0, last, 2'b00, fin, 1'b1});
  endtask : start
  // Wait for a segment start, then report arrival or a negative speed change.
  task automatic step(input logic neg);
    `WAITFOR(seg_start === 1'b1)
    repeat (2) @(posedge pclk);
    if (neg) speed_neg <= 1'b1;
    else seg_done <= 1'b1;
    @(posedge pclk);
    speed_neg <= 1'b0;
    seg_done <= 1'b0;
  endtask : step
  // Verdict and end of run.
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////
  // Output watcher: each segment start takes the oldest note; the strobe is judged every cycle.
  // Sampling at the edge sees the values settled in the cycle before it.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      test_done;
    end
    if (presetn && seg_start === 1'b1) begin
      x = exp_q.size() ? exp_q.pop_front() : 18'h3ffff;
      `CHK({speed_switch, speed_circ, point_idx, tag_valid, tag_code}, x[16:0])
      if (x[17]) `CHK({ack_seen, fin_ack_in}, 5'h10)
    end
    if (presetn && tv_d != 4'h0 && tag_valid != 4'h0) `CHK(tag_code, tag_d)
    if (cnt == 4'h2) `CHK(tag_valid, 4'h0)
    cnt = (|fin_ack_in && !ack_d) ? 4'h4 : (cnt != 4'h0 ? cnt - 4'h1 : 4'h0);
    ack_seen = (seg_start === 1'b1) ? 1'b0 : (ack_seen | (|fin_ack_in));
    ack_d = |fin_ack_in;
    tv_d = tag_valid;
    tag_d = tag_code;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {psel, penable, pwrite, seg_done, speed_neg, presetn, ack_seen, ack_d} = 8'h00;
    {paddr, pwdata, skip_in, ack_sel, tv_d, tag_d, cnt} = '0;
    ack_dly = 4'h6;
    rnd = 32'd4957;
    n_fail = 0;
    tests_run = 0;
    cyc = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and an unmapped place.
    apb(1'b0, `PPH_A_STATUS, 32'h0);
    `CHK(r, 32'h0)
    `CHK(ramp_ms, `PPH_RAMP_DEF)
    apb(1'b0, 12'h0fc, 32'h0);
    `CHK(e, 1'b1)
    // Ramp values at and beyond both ends, then the indirect word.
    pt(0, 8'h00, 2'h0, 5'h00);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, `PPH_A_RAMP, k == 4 ? 32'h10000 : (k == 0 ? 32'h0 : (k == 1 ? 32'd5001 : (k - 2) * 4999 + 1)));
      apb(1'b1, `PPH_A_DWORD, 32'd200);
      apb(1'b1, `PPH_A_ERR, 32'h0);
      exp_q.push_back(18'h00000);
      start(1'b1, 3'h0, 4'h3);
      step(1'b0);
      `WAITFOR(path_done === 1'b1)
      `CHK(path_done, 1'b1)
      `CHK(fixed_ramp, 1'b1)
      `CHK(ramp_ms, k == 4 ? 16'd200 : (k < 2 ? `PPH_RAMP_DEF : 16'((k - 2) * 4999 + 1)))
      apb(1'b0, `PPH_A_ERR, 32'h0);
      `CHK(r[7:0], k < 2 ? `PPH_ERR_RAMP : 8'h00)
    end
    // Tagged path in fin mode on three of four axes; the helical point carries the switch flag.
    rnd = xs(rnd);
    ack_sel <= 2'(rnd[7:0] % 3);
    ack_dly <= 4'h5 + 4'(rnd[9:8]);
    for (int i = 0; i < 3; i++) begin
      rnd = xs(rnd);
      t = rnd[7:0] | 8'h01;
      pt(i, t, 2'(i == 2 ? 1 : i * 2), {3'b000, i == 1, 1'b1});
      exp_q.push_back({i > 0, i == 1, i == 1, 3'(i), 4'h7, t});
    end
    start(1'b1, 3'h2, 4'h7);
    for (int i = 0; i < 3; i++) step(1'b0);
    `WAITFOR(path_done === 1'b1)
    `CHK({ack_seen, fin_ack_in}, 5'h10)
    // Skip through four points, one skip input each; the last skip stops the path.
    // Only linear points are used, so no absolute arc follows a skip point.
    for (int k = 0; k < 4; k++) begin
      pt(k, 8'h00, 2'h0, {2'(k), 3'b100});
      exp_q.push_back({3'h0, 3'(k), 12'h000});
    end
    start(1'b0, 3'h3, 4'h3);
    for (int k = 0; k < 4; k++) begin
      `WAITFOR(seg_start === 1'b1)
      repeat (2) @(posedge pclk);
      skip_in[k] <= 1'b1;
      if (k == 3) `WAITFOR(decel_stop === 1'b1)
      else repeat (2) @(posedge pclk);
      skip_in <= 4'h0;
    end
    `CHK(decel_stop, 1'b1)
    // The interpolator reports the stop, which ends the cut path.
    seg_done <= 1'b1;
    @(posedge pclk);
    seg_done <= 1'b0;
    `WAITFOR(path_done === 1'b1)
    `CHK(path_done, 1'b1)
    repeat (10) @(posedge pclk);
    apb(1'b0, `PPH_A_STATUS, 32'h0);
    `CHK(r[8], 1'b0)
    // Negative speed change on the helical point steps back one point.
    for (int i = 0; i < 3; i++) pt(i, 8'h00, 2'(i == 1 ? 2 : 0), 5'h00);
    for (int i = 0; i < 5; i++) exp_q.push_back({2'b00, i[0], 3'(i == 4 ? 2 : i[0]), 12'h000});
    start(1'b0, 3'h2, 4'h7);
    step(1'b0);
    step(1'b1);
    for (int i = 0; i < 3; i++) step(1'b0);
    `WAITFOR(path_done === 1'b1)
    `CHK(path_done, 1'b1)
    `CHK(exp_q.size(), 0)
    test_done;
  end
endmodule : pph_path_seq_tb_top
